//--- hdl/cpu_processor_registers.sv
// Processor control registers, stack sequencing and general register set
`timescale 1ns/1ps
module cpu_processor_registers #(
   parameter int N_SRC = 12
) (
   // Clock, reset, enable
   input  wire logic                       core_clk,
   input  wire logic                       nrst,
   input  wire logic                       clk_en,
   // Command from the sequencer
   input  wire logic                       cmd_valid,
   input  wire cpu_regs_pkg::cmd_t         cmd,
   output logic                            cmd_ready,
   // Register views
   output logic      [15:0]                fetch_pointer,
   output logic      [7:0]                 status_word,
   output logic      [15:0]                stack_top_pointer,
   input  wire logic [2:0]                 gpr_rd_idx,
   output logic      [7:0]                 gpr_rd_byte,
   output logic      [15:0]                gpr_rd_pair,
   // Program memory read
   output logic                            prog_rd,
   output logic      [15:0]                prog_addr,
   input  wire logic [7:0]                 prog_data,
   // Stack memory
   output logic                            stk_wr,
   output logic                            stk_rd,
   output logic      [15:0]                stk_addr,
   output logic      [7:0]                 stk_wdata,
   input  wire logic [7:0]                 stk_rdata,
   output logic                            stk_fault,
   // Interrupts
   input  wire logic [N_SRC-1:0]           int_req,
   input  wire logic [N_SRC-1:0]           int_mask,
   input  wire logic                       nmi_req,
   output logic                            int_ack,
   output logic      [3:0]                 int_src,
   output logic                            int_nmi,
   // Special register access check
   input  wire cpu_regs_pkg::sfr_req_t     sfr,
   output logic                            sfr_hit,
   output logic                            sfr_refused
);
   generate
      if (N_SRC < 1 || N_SRC > cpu_regs_pkg::MAX_SOURCES) begin : g_bad_src
         $error("N_SRC out of range");
      end
   endgenerate

   typedef enum logic [3:0] {
      ST_VEC_LO, ST_VEC_HI, ST_VEC_W1, ST_VEC_W2, ST_RUN,
      ST_PAIR_RD, ST_PUSH, ST_POP, ST_POP_WAIT
   } state_t;

   state_t       state_reg, state_next;
   cpu_regs_pkg::op_t pend_reg;
   logic [15:0]  pend_data_reg;
   logic [2:0]   pend_idx_reg;
   logic [1:0]   cnt_reg;
   logic [23:0]  push_reg, pop_reg;
   logic [15:0]  vec_reg;
   logic [7:0]   vec_lo_reg;
   logic         rd_d_reg;
   logic         accept, int_take, irq_any, is_intr;
   logic [3:0]   src_sel;
   logic         push_last, pop_done;
   logic [8:0]   sum9;
   logic         half;
   logic [15:0]  sp_dec;
   logic         we_lo, we_hi;
   logic [1:0]   wr_pair;
   logic [15:0]  wdata;

   assign accept    = (state_reg == ST_RUN) && cmd_valid;
   assign push_last = (state_reg == ST_PUSH) && (cnt_reg == 2'h1);
   assign pop_done  = (state_reg == ST_POP_WAIT) && !stk_rd && !rd_d_reg;
   assign sp_dec    = stack_top_pointer - 16'h0001;
   assign is_intr   = (pend_reg == cpu_regs_pkg::OP_NOP);

   // Interrupt acceptance and lowest-index source select
   always_comb begin
      irq_any = nmi_req;
      src_sel = 4'h0;
      if (status_word[cpu_regs_pkg::PSW_IE_BIT]) begin
         irq_any = nmi_req || |(int_req & ~int_mask);
      end
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (int_req[i] && !int_mask[i]) begin
            src_sel = 4'(i);
         end
      end
   end
   assign int_take = (state_reg == ST_RUN) && !cmd_valid && irq_any;

   // Flag arithmetic
   always_comb begin
      if (cmd.op == cpu_regs_pkg::OP_FL_SUB) begin
         sum9 = {1'b0, cmd.data[15:8]} - {1'b0, cmd.data[7:0]};
         half = cmd.data[11:8] < cmd.data[3:0];
      end else begin
         sum9 = {1'b0, cmd.data[15:8]} + {1'b0, cmd.data[7:0]};
         half = 5'({1'b0, cmd.data[11:8]} + {1'b0, cmd.data[3:0]}) > 5'h0f;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_VEC_LO: state_next = ST_VEC_HI;
         ST_VEC_HI: state_next = ST_VEC_W1;
         ST_VEC_W1: state_next = ST_VEC_W2;
         ST_VEC_W2: state_next = ST_RUN;
         ST_RUN: begin
            if (int_take) begin
               state_next = ST_PUSH;
            end else if (cmd_valid) begin
               unique case (cmd.op)
                  cpu_regs_pkg::OP_CALL,
                  cpu_regs_pkg::OP_PUSH_PSW:   state_next = ST_PUSH;
                  cpu_regs_pkg::OP_PUSH_PAIR,
                  cpu_regs_pkg::OP_BR_PAIR:    state_next = ST_PAIR_RD;
                  cpu_regs_pkg::OP_RET,
                  cpu_regs_pkg::OP_INTERRUPT_RETURN_INSTR,
                  cpu_regs_pkg::OP_POP_PSW,
                  cpu_regs_pkg::OP_POP_PAIR:   state_next = ST_POP;
                  default:                     state_next = ST_RUN;
               endcase
            end
         end
         ST_PAIR_RD: state_next = (pend_reg == cpu_regs_pkg::OP_BR_PAIR) ? ST_RUN : ST_PUSH;
         ST_PUSH: begin
            if (cnt_reg == 2'h1) begin
               state_next = is_intr ? ST_VEC_LO : ST_RUN;
            end
         end
         ST_POP: begin
            if (cnt_reg == 2'h1) begin
               state_next = ST_POP_WAIT;
            end
         end
         ST_POP_WAIT: begin
            if (pop_done) begin
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_VEC_LO;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_reg <= ST_VEC_LO;
         cmd_ready <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         cmd_ready <= (state_next == ST_RUN);
      end
   end

   // Pending operation, byte counts and push data
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pend_reg      <= cpu_regs_pkg::OP_NOP;
         pend_data_reg <= 16'h0000;
         pend_idx_reg  <= 3'h0;
         cnt_reg       <= 2'h0;
         push_reg      <= 24'h000000;
         vec_reg       <= cpu_regs_pkg::RESET_VECTOR;
      end else if (clk_en) begin
         if (int_take) begin
            pend_reg <= cpu_regs_pkg::OP_NOP;
            cnt_reg  <= cpu_regs_pkg::INTR_BYTES;
            push_reg <= {status_word, fetch_pointer};
            vec_reg  <= nmi_req ? cpu_regs_pkg::NMI_VECTOR
                                : cpu_regs_pkg::INT_VEC_BASE + {11'h000, src_sel, 1'b0};
         end else if (accept) begin
            pend_reg      <= cmd.op;
            pend_data_reg <= cmd.data;
            pend_idx_reg  <= cmd.idx;
            unique case (cmd.op)
               cpu_regs_pkg::OP_CALL: begin
                  cnt_reg  <= cpu_regs_pkg::CALL_BYTES;
                  push_reg <= {fetch_pointer, 8'h00};
               end
               cpu_regs_pkg::OP_PUSH_PSW: begin
                  cnt_reg  <= cpu_regs_pkg::PSW_BYTES;
                  push_reg <= {status_word, 16'h0000};
               end
               cpu_regs_pkg::OP_INTERRUPT_RETURN_INSTR:     cnt_reg <= cpu_regs_pkg::INTR_BYTES;
               cpu_regs_pkg::OP_POP_PSW:  cnt_reg <= cpu_regs_pkg::PSW_BYTES;
               default:                   cnt_reg <= cpu_regs_pkg::CALL_BYTES;
            endcase
         end else if (state_reg == ST_PAIR_RD) begin
            push_reg <= {gpr_rd_pair, 8'h00};
         end else if (state_reg == ST_PUSH) begin
            push_reg <= {push_reg[15:0], 8'h00};
            cnt_reg  <= cnt_reg - 2'h1;
         end else if (state_reg == ST_POP) begin
            cnt_reg  <= cnt_reg - 2'h1;
         end
      end
   end

   // Fetch pointer
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         fetch_pointer <= cpu_regs_pkg::RESET_VECTOR;
      end else if (clk_en) begin
         if (state_reg == ST_VEC_W2) begin
            fetch_pointer <= {prog_data, vec_lo_reg};
         end else if (accept && cmd.op == cpu_regs_pkg::OP_ADVANCE) begin
            fetch_pointer <= fetch_pointer + {13'h0000, cmd.data[2:0]};
         end else if (accept && cmd.op == cpu_regs_pkg::OP_BR_IMM) begin
            fetch_pointer <= cmd.data;
         end else if (state_reg == ST_PAIR_RD && pend_reg == cpu_regs_pkg::OP_BR_PAIR) begin
            fetch_pointer <= gpr_rd_pair;
         end else if (push_last && pend_reg == cpu_regs_pkg::OP_CALL) begin
            fetch_pointer <= pend_data_reg;
         end else if (pop_done && pend_reg == cpu_regs_pkg::OP_RET) begin
            fetch_pointer <= pop_reg[23:8];
         end else if (pop_done && pend_reg == cpu_regs_pkg::OP_INTERRUPT_RETURN_INSTR) begin
            fetch_pointer <= pop_reg[15:0];
         end
      end
   end

   // Status word
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         status_word <= cpu_regs_pkg::PSW_RESET;
      end else if (clk_en) begin
         if (int_take) begin
            status_word[cpu_regs_pkg::PSW_IE_BIT] <= 1'b0;
         end else if (accept) begin
            unique case (cmd.op)
               cpu_regs_pkg::OP_EI: status_word[cpu_regs_pkg::PSW_IE_BIT] <= 1'b1;
               cpu_regs_pkg::OP_DI: status_word[cpu_regs_pkg::PSW_IE_BIT] <= 1'b0;
               cpu_regs_pkg::OP_WR_PSW: status_word <= cpu_regs_pkg::fix_psw(cmd.data[7:0]);
               cpu_regs_pkg::OP_FL_ADD,
               cpu_regs_pkg::OP_FL_SUB: begin
                  status_word[cpu_regs_pkg::PSW_Z_BIT]  <= (sum9[7:0] == 8'h00);
                  status_word[cpu_regs_pkg::PSW_AC_BIT] <= half;
                  status_word[cpu_regs_pkg::PSW_CY_BIT] <= sum9[8];
               end
               cpu_regs_pkg::OP_FL_ROT,
               cpu_regs_pkg::OP_FL_BIT: status_word[cpu_regs_pkg::PSW_CY_BIT] <= cmd.data[0];
               default: status_word <= status_word;
            endcase
         end else if (pop_done && (pend_reg == cpu_regs_pkg::OP_POP_PSW
                                   || pend_reg == cpu_regs_pkg::OP_INTERRUPT_RETURN_INSTR)) begin
            status_word <= cpu_regs_pkg::fix_psw(pop_reg[23:16]);
         end
      end
   end

   // Stack pointer; reset value carries no meaning until software loads it
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stack_top_pointer <= cpu_regs_pkg::SP_RESET;
      end else if (clk_en) begin
         if (accept && cmd.op == cpu_regs_pkg::OP_LOAD_SP) begin
            stack_top_pointer <= cmd.data;
         end else if (state_reg == ST_PUSH) begin
            stack_top_pointer <= sp_dec;
         end else if (state_reg == ST_POP) begin
            stack_top_pointer <= stack_top_pointer + 16'h0001;
         end
      end
   end

   // Stack memory traffic
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stk_wr    <= 1'b0;
         stk_rd    <= 1'b0;
         stk_addr  <= 16'h0000;
         stk_wdata <= 8'h00;
         stk_fault <= 1'b0;
      end else if (clk_en) begin
         stk_wr <= 1'b0;
         stk_rd <= 1'b0;
         if (state_reg == ST_PUSH) begin
            stk_addr  <= sp_dec;
            stk_wdata <= push_reg[23:16];
            stk_wr    <= cpu_regs_pkg::in_stack_ram(sp_dec);
            stk_fault <= !cpu_regs_pkg::in_stack_ram(sp_dec);
         end else if (state_reg == ST_POP) begin
            stk_addr  <= stack_top_pointer;
            stk_rd    <= cpu_regs_pkg::in_stack_ram(stack_top_pointer);
            stk_fault <= !cpu_regs_pkg::in_stack_ram(stack_top_pointer);
         end
      end
   end

   // Restored byte capture, lowest address ends lowest
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rd_d_reg <= 1'b0;
         pop_reg  <= 24'h000000;
      end else if (clk_en) begin
         rd_d_reg <= stk_rd;
         if (accept) begin
            pop_reg <= 24'h000000;
         end else if (rd_d_reg) begin
            pop_reg <= {stk_rdata, pop_reg[23:8]};
         end
      end
   end

   // Program memory reads for vectors
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prog_rd    <= 1'b0;
         prog_addr  <= 16'h0000;
         vec_lo_reg <= 8'h00;
      end else if (clk_en) begin
         prog_rd <= 1'b0;
         if (state_reg == ST_VEC_LO) begin
            prog_rd   <= 1'b1;
            prog_addr <= vec_reg;
         end else if (state_reg == ST_VEC_HI) begin
            prog_rd   <= 1'b1;
            prog_addr <= vec_reg + 16'h0001;
         end else if (state_reg == ST_VEC_W1) begin
            vec_lo_reg <= prog_data;
         end
      end
   end

   // Interrupt acknowledge
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         int_ack <= 1'b0;
         int_src <= 4'h0;
         int_nmi <= 1'b0;
      end else if (clk_en) begin
         int_ack <= int_take;
         if (int_take) begin
            int_src <= src_sel;
            int_nmi <= nmi_req;
         end
      end
   end

   // Special register window and width check
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sfr_hit     <= 1'b0;
         sfr_refused <= 1'b0;
      end else if (clk_en) begin
         sfr_hit     <= sfr.req && (sfr.addr[15:8] == cpu_regs_pkg::SFR_BASE[15:8]);
         sfr_refused <= sfr.req && (sfr.width == cpu_regs_pkg::SFR_W16)
                        && sfr.addr[0];
      end
   end

   // General register writes
   always_comb begin
      we_lo   = 1'b0;
      we_hi   = 1'b0;
      wr_pair = cmd.idx[2:1];
      wdata   = cmd.data;
      if (accept && cmd.op == cpu_regs_pkg::OP_WR_BYTE) begin
         we_lo = !cmd.idx[0];
         we_hi = cmd.idx[0];
         wdata = {cmd.data[7:0], cmd.data[7:0]};
      end else if (accept && cmd.op == cpu_regs_pkg::OP_WR_PAIR) begin
         we_lo = 1'b1;
         we_hi = 1'b1;
      end else if (pop_done && pend_reg == cpu_regs_pkg::OP_POP_PAIR) begin
         we_lo   = 1'b1;
         we_hi   = 1'b1;
         wr_pair = pend_idx_reg[2:1];
         wdata   = pop_reg[23:8];
      end
   end

   gpr_bank u_gpr (
      .core_clk (core_clk),
      .en       (clk_en),
      .wr_pair  (wr_pair),
      .we_lo    (we_lo),
      .we_hi    (we_hi),
      .wdata    (wdata),
      .rd_idx   (accept ? cmd.idx : gpr_rd_idx),
      .rd_byte  (gpr_rd_byte),
      .rd_pair  (gpr_rd_pair)
   );
endmodule // cpu_processor_registers

//--- hdl/cpu_regs_pkg.sv
// Constants, types and helper functions shared by the processor register set
// What this block does
// - Sixteen-bit fetch pointer holds next fetch address
// - Sequential fetch adds instruction byte length
// - Branch loads immediate value or register pair
// - Reset loads fetch pointer from vector bytes
// - Vector low byte even, high byte odd
// - Status word bit layout with fixed bits
// - Status word saved on interrupt, push; restored
// - Reset sets status word to 02h
// - Master enable low blocks all maskable requests
// - Master enable high: per-source mask decides
// - Disable or acknowledge clears enable; enable sets
// - Zero flag reflects result equal zero
// - Half carry from carry or borrow bit 3
// - Carry: add/sub overflow, rotate out, bit accumulator
// - Sixteen-bit stack pointer, stack only internal RAM
// - Pre-decrement on save, post-increment on restore
// - Stack pointer undefined after reset; program loads it
// - Eight independent byte-wide general registers
// - Even/odd byte pairs form four pairs
// - Special registers occupy top 256-byte window
// - Special register width per register; 16-bit even
package cpu_regs_pkg;

   localparam logic [15:0] RESET_VECTOR   = 16'h0000;
   localparam logic [15:0] NMI_VECTOR     = 16'h0004;
   localparam logic [15:0] INT_VEC_BASE   = 16'h0006;
   localparam int          MAX_SOURCES    = 12;
   localparam logic [7:0]  PSW_RESET      = 8'h02;
   localparam logic [7:0]  PSW_KEEP_MASK  = 8'hd1;
   localparam logic [7:0]  PSW_ONE_MASK   = 8'h02;
   localparam int          PSW_IE_BIT     = 7;
   localparam int          PSW_Z_BIT      = 6;
   localparam int          PSW_AC_BIT     = 4;
   localparam int          PSW_CY_BIT     = 0;
   localparam logic [15:0] SP_RESET       = 16'h0000;
   localparam logic [15:0] STACK_RAM_LO   = 16'hfe00;
   localparam logic [15:0] STACK_RAM_HI   = 16'hfeff;
   localparam logic [15:0] SFR_BASE       = 16'hff00;
   localparam logic [1:0]  INTR_BYTES     = 2'h3;
   localparam logic [1:0]  CALL_BYTES     = 2'h2;
   localparam logic [1:0]  PSW_BYTES      = 2'h1;

   typedef enum logic [4:0] {
      OP_NOP, OP_ADVANCE, OP_BR_IMM, OP_BR_PAIR, OP_CALL, OP_RET, OP_INTERRUPT_RETURN_INSTR,
      OP_PUSH_PSW, OP_POP_PSW, OP_PUSH_PAIR, OP_POP_PAIR, OP_EI, OP_DI,
      OP_LOAD_SP, OP_WR_BYTE, OP_WR_PAIR, OP_WR_PSW,
      OP_FL_ADD, OP_FL_SUB, OP_FL_ROT, OP_FL_BIT
   } op_t;

   typedef enum logic [1:0] {SFR_W1, SFR_W8, SFR_W16} sfr_width_t;

   typedef struct packed {
      op_t         op;
      logic [2:0]  idx;
      logic [15:0] data;
   } cmd_t;

   typedef struct packed {
      logic [15:0] addr;
      sfr_width_t  width;
      logic        req;
   } sfr_req_t;

   // Forces the fixed bits of the status word
   function automatic logic [7:0] fix_psw(input logic [7:0] v);
      return (v & PSW_KEEP_MASK) | PSW_ONE_MASK;
   endfunction

   function automatic logic in_stack_ram(input logic [15:0] a);
      return (a >= STACK_RAM_LO) && (a <= STACK_RAM_HI);
   endfunction

endpackage

//--- hdl/gpr_bank.sv
// Eight byte general registers with byte and pair access, registered read
`timescale 1ns/1ps
module gpr_bank (
   // Clock and enable
   input  wire logic        core_clk,
   input  wire logic        en,
   // Write side
   input  wire logic [1:0]  wr_pair,
   input  wire logic        we_lo,
   input  wire logic        we_hi,
   input  wire logic [15:0] wdata,
   // Read side
   input  wire logic [2:0]  rd_idx,
   output logic      [7:0]  rd_byte,
   output logic      [15:0] rd_pair
);
   logic [7:0] mem [8];

   always_ff @(posedge core_clk) begin
      if (en) begin
         if (we_lo) begin
            mem[{wr_pair, 1'b0}] <= wdata[7:0];
         end
         if (we_hi) begin
            mem[{wr_pair, 1'b1}] <= wdata[15:8];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (en) begin
         rd_byte <= mem[rd_idx];
         rd_pair <= {mem[{rd_idx[2:1], 1'b1}], mem[{rd_idx[2:1], 1'b0}]};
      end
   end
endmodule // gpr_bank

//--- sim/cpu_regs_props.sv
// Port assertions for the processor register set
`timescale 1ns/1ps
module cpu_regs_props #(parameter int N_SRC = 12) (
   // Clock, reset, command
   input wire logic core_clk, nrst, clk_en, cmd_valid, cmd_ready,
   input wire cpu_regs_pkg::cmd_t cmd,
   // Views and strobes
   input wire logic [15:0] fetch_pointer, stack_top_pointer, prog_addr, stk_addr,
   input wire logic [7:0] status_word,
   input wire logic prog_rd, stk_wr, int_ack, int_nmi, sfr_hit, sfr_refused,
   // Interrupts and special access
   input wire logic [N_SRC-1:0] int_req, int_mask,
   input wire logic [3:0] int_src,
   input wire cpu_regs_pkg::sfr_req_t sfr
);
   logic [N_SRC-1:0] elig_q;
   wire go = clk_en && cmd_valid && cmd_ready;
   always_ff @(posedge core_clk) begin
      elig_q <= int_req & ~int_mask;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_fixed_psw_bits: assert property ((status_word & 8'h2e) == 8'h02)
      else $error("status word fixed bits wrong");
   a_reset_psw: assert property (disable iff (1'b0) !nrst && clk_en |=>
      status_word == 8'h02 && !cmd_ready) else $error("reset state wrong");
   a_vector_fetch: assert property (disable iff (1'b0) !nrst ##1 nrst |=>
      prog_rd && prog_addr == 16'h0000 ##1 prog_addr == 16'h0001)
      else $error("vector fetch order wrong");
   a_ie_blocks_int: assert property (int_ack && !int_nmi |-> $past(status_word[7]))
      else $error("maskable taken with enable low");
   a_src_unmasked: assert property (int_ack && !int_nmi |-> elig_q[int_src])
      else $error("acknowledged source not pending and unmasked");
   a_ack_clears_ie: assert property (int_ack |-> !status_word[7])
      else $error("enable not cleared on acknowledge");
   a_enable_sets: assert property (go && cmd.op == cpu_regs_pkg::OP_EI |=> status_word[7])
      else $error("enable instruction failed");
   a_advance_len: assert property (go && cmd.op == cpu_regs_pkg::OP_ADVANCE |=>
      fetch_pointer == $past(fetch_pointer) + {13'h0000, $past(cmd.data[2:0])})
      else $error("sequential advance wrong");
   a_branch_imm: assert property (go && cmd.op == cpu_regs_pkg::OP_BR_IMM |=>
      fetch_pointer == $past(cmd.data)) else $error("branch target wrong");
   a_push_predec: assert property (stk_wr |-> stk_addr == stack_top_pointer)
      else $error("save not at decremented pointer");
   a_sfr_window: assert property (sfr.req |=>
      sfr_hit == ($past(sfr.addr[15:8]) == 8'hff)) else $error("window hit wrong");
   a_sfr_even_addr: assert property (sfr.req |=> sfr_refused ==
      ($past(sfr.width) == cpu_regs_pkg::SFR_W16 && $past(sfr.addr[0])))
      else $error("odd pair access check wrong");
   c_nmi_taken: cover property (int_ack && int_nmi);
   c_stack_save: cover property (stk_wr);
   c_sfr_refused: cover property (sfr_refused);
endmodule // cpu_regs_props

//--- sim/test_cpu_processor_registers.sv
// Self-checking bench for the processor register set
`timescale 1ns/1ps
module test_cpu_processor_registers;
   localparam int N_SRC = 12;
   typedef struct {cpu_regs_pkg::op_t op; logic [2:0] idx; logic [15:0] data;
                   int sel; logic [15:0] exp;} row_t;
   logic core_clk = 0, nrst = 0, clk_en = 1, cmd_valid = 0, nmi_req = 0;
   cpu_regs_pkg::cmd_t cmd = '0;
   cpu_regs_pkg::sfr_req_t sfr = '0;
   logic [2:0] gpr_rd_idx = 0;
   logic [7:0] prog_data = 0, stk_rdata = 0, stack_mem [256];
   logic [15:0] pa_q = 0, sa_q = 0;
   logic [N_SRC-1:0] int_req = 0, int_mask = 0;
   logic cmd_ready, prog_rd, stk_wr, stk_rd, stk_fault, int_ack, int_nmi, sfr_hit, sfr_refused;
   logic [15:0] fetch_pointer, stack_top_pointer, gpr_rd_pair, prog_addr, stk_addr;
   logic [7:0] status_word, gpr_rd_byte, stk_wdata;
   logic [3:0] int_src;
   int failures = 0, n_tests = 0, cycles = 0;
   row_t rows [] = '{
      '{cpu_regs_pkg::OP_BR_IMM, 0, 16'h1234, 0, 16'h1234},
      '{cpu_regs_pkg::OP_ADVANCE, 0, 16'h0007, 0, 16'h123b},
      '{cpu_regs_pkg::OP_ADVANCE, 0, 16'h0003, 0, 16'h123e},
      '{cpu_regs_pkg::OP_WR_PSW, 0, 16'h00ff, 1, 16'h00d3},
      '{cpu_regs_pkg::OP_DI, 0, 16'h0000, 1, 16'h0053},
      '{cpu_regs_pkg::OP_EI, 0, 16'h0000, 1, 16'h00d3},
      '{cpu_regs_pkg::OP_WR_PSW, 0, 16'h0000, 1, 16'h0002},
      '{cpu_regs_pkg::OP_FL_ADD, 0, 16'h0f01, 1, 16'h0012},
      '{cpu_regs_pkg::OP_FL_ADD, 0, 16'hff01, 1, 16'h0053},
      '{cpu_regs_pkg::OP_FL_SUB, 0, 16'h1001, 1, 16'h0012},
      '{cpu_regs_pkg::OP_FL_SUB, 0, 16'h0001, 1, 16'h0013},
      '{cpu_regs_pkg::OP_FL_SUB, 0, 16'h0505, 1, 16'h0042},
      '{cpu_regs_pkg::OP_FL_ROT, 0, 16'h0001, 4, 16'h0001},
      '{cpu_regs_pkg::OP_FL_BIT, 0, 16'h0000, 4, 16'h0000},
      '{cpu_regs_pkg::OP_LOAD_SP, 0, 16'hfee0, 2, 16'hfee0},
      '{cpu_regs_pkg::OP_WR_BYTE, 0, 16'h0034, 5, 16'h0034},
      '{cpu_regs_pkg::OP_WR_BYTE, 1, 16'h0012, 3, 16'h1234},
      '{cpu_regs_pkg::OP_WR_PAIR, 6, 16'habcd, 5, 16'h00cd},
      '{cpu_regs_pkg::OP_BR_PAIR, 6, 16'h0000, 0, 16'habcd},
      '{cpu_regs_pkg::OP_BR_IMM, 0, 16'h123e, 0, 16'h123e}};
   cpu_processor_registers #(.N_SRC(N_SRC)) u_cpu_processor_registers (.*);
   always #2.5 core_clk = ~core_clk;
   function automatic logic [7:0] rom(input logic [15:0] a);
      return a[7:0] ^ 8'h5a;
   endfunction
   // Program and stack memories answer at the second falling edge after the request
   always @(negedge core_clk) begin
      prog_data <= rom(pa_q);
      pa_q <= prog_addr;
      stk_rdata <= stack_mem[sa_q[7:0]];
      sa_q <= stk_addr;
      if (stk_wr) stack_mem[stk_addr[7:0]] <= stk_wdata;
   end
   function automatic logic [15:0] view(int sel);
      case (sel)
         0: return fetch_pointer;
         1: return {8'h00, status_word};
         2: return stack_top_pointer;
         3: return gpr_rd_pair;
         4: return {15'h0000, status_word[0]};
         default: return {8'h00, gpr_rd_byte};
      endcase
   endfunction
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_ready;
      for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge core_clk);
   endtask
   task automatic wait_ack;
      for (int i = 0; i < 50 && int_ack !== 1'b1; i++) @(negedge core_clk);
   endtask
   task automatic send(cpu_regs_pkg::op_t op, logic [2:0] idx, logic [15:0] data);
      wait_ready;
      cmd_valid = 1;
      cmd = '{op, idx, data};
      @(negedge core_clk);
      cmd_valid = 0;
      @(negedge core_clk);
      wait_ready;
   endtask
   task automatic sfr_try(logic [15:0] a, cpu_regs_pkg::sfr_width_t w, logic [1:0] e);
      sfr = '{a, w, 1'b1};
      @(negedge core_clk);
      check("sfr hit refused", {14'h0000, e}, {14'h0000, sfr_hit, sfr_refused});
      sfr.req = 0;
      @(negedge core_clk);
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         close_out;
      end
   end
   initial begin
      repeat (8) @(negedge core_clk);
      check("reset status", 16'h0002, view(1));
      nrst = 1;
      @(negedge core_clk);
      wait_ready;
      check("vector", {rom(16'h0001), rom(16'h0000)}, fetch_pointer);
      foreach (rows[i]) begin
         gpr_rd_idx = rows[i].idx;
         send(rows[i].op, rows[i].idx, rows[i].data);
         check("row view", rows[i].exp, view(rows[i].sel));
      end
      clk_en = 0;
      cmd_valid = 1;
      cmd = '{cpu_regs_pkg::OP_ADVANCE, 3'h0, 16'h0001};
      repeat (3) @(negedge core_clk);
      check("frozen", 16'h123e, fetch_pointer);
      clk_en = 1;
      @(negedge core_clk);
      cmd_valid = 0;
      check("advance", 16'h123f, fetch_pointer);
      @(negedge core_clk);
      send(cpu_regs_pkg::OP_CALL, 0, 16'h2000);
      check("call sp", 16'hfede, stack_top_pointer);
      @(negedge core_clk);
      check("call saved", 16'h123f, {stack_mem[8'hdf], stack_mem[8'hde]});
      send(cpu_regs_pkg::OP_RET, 0, 16'h0000);
      check("ret target", 16'h123f, fetch_pointer);
      check("ret sp", 16'hfee0, stack_top_pointer);
      send(cpu_regs_pkg::OP_WR_PSW, 0, 16'h0011);
      send(cpu_regs_pkg::OP_PUSH_PSW, 0, 16'h0000);
      send(cpu_regs_pkg::OP_WR_PSW, 0, 16'h0000);
      send(cpu_regs_pkg::OP_POP_PSW, 0, 16'h0000);
      check("psw restored", 16'h0013, view(1));
      check("psw sp", 16'hfee0, stack_top_pointer);
      send(cpu_regs_pkg::OP_EI, 0, 16'h0000);
      int_mask = 12'hffb;
      int_req = 12'h00c;
      wait_ack;
      check("int src", 16'h0002, {12'h000, int_src});
      int_req = 0;
      wait_ready;
      check("int vector", {rom(16'h000b), rom(16'h000a)}, fetch_pointer);
      check("int psw", 16'h0013, view(1));
      check("int sp", 16'hfedd, stack_top_pointer);
      check("int saved", 16'h93_12, {stack_mem[8'hdf], stack_mem[8'hde]});
      send(cpu_regs_pkg::OP_INTERRUPT_RETURN_INSTR, 0, 16'h0000);
      check("interrupt_return_instr psw", 16'h0093, view(1));
      check("interrupt_return_instr target", 16'h123f, fetch_pointer);
      int_req = 12'h008;
      repeat (10) @(negedge core_clk);
      check("masked source", 16'h123f, fetch_pointer);
      send(cpu_regs_pkg::OP_DI, 0, 16'h0000);
      int_mask = 0;
      repeat (10) @(negedge core_clk);
      check("disabled", 16'h123f, fetch_pointer);
      nmi_req = 1;
      wait_ack;
      check("nmi flag", 16'h0001, {15'h0000, int_nmi});
      nmi_req = 0;
      int_req = 0;
      wait_ready;
      check("nmi vector", {rom(16'h0005), rom(16'h0004)}, fetch_pointer);
      send(cpu_regs_pkg::OP_LOAD_SP, 0, 16'h0000);
      send(cpu_regs_pkg::OP_PUSH_PSW, 0, 16'h0000);
      check("stack fault", 16'h0001, {15'h0000, stk_fault});
      sfr_try(16'hff00, cpu_regs_pkg::SFR_W16, 2'b10);
      sfr_try(16'hff01, cpu_regs_pkg::SFR_W16, 2'b11);
      sfr_try(16'hfe00, cpu_regs_pkg::SFR_W8, 2'b00);
      sfr_try(16'hff03, cpu_regs_pkg::SFR_W1, 2'b10);
      close_out;
   end
endmodule // test_cpu_processor_registers
bind cpu_processor_registers cpu_regs_props #(.N_SRC(N_SRC)) u_props (.*);
